// ===== rtl/dpram_pkg.sv
// Purpose: types shared by the dual-port ram port logic
// Assumes: constants from dpram_regs.svh
// Notes:   one struct carries every synchronous input of a port
`include "dpram_regs.svh"

package dpram_pkg;

   // ****************************************************************
   // per-port input bundle
   // ****************************************************************
   typedef struct packed {
      logic                 cs_low_n;
      logic                 cs_high;
      logic                 read_not_write;
      logic                 upper_n;
      logic                 lower_n;
      logic                 load_n;
      logic                 advance_n;
      logic                 clear_n;
      logic                 pipe_mode;
      logic [`ADDR_MSB:0]   addr;
      logic [`DATA_MSB:0]   wdata;
   } port_in_t;

   // ****************************************************************
   // registered control of one port
   // ****************************************************************
   typedef struct packed {
      logic                 sel;
      logic                 read_not_write;
      logic                 upper_n;
      logic                 lower_n;
      logic                 pipe_mode;
   } port_ctl_t;

endpackage : dpram_pkg

// ===== rtl/dpram_ports.sv
// Purpose: two synchronous ports of an 18-bit wide dual-port ram
// Assumes: port clocks and pins are slower than SYS_CLK by 3 or more
// Notes:   each port clock is sampled, its rise becomes an enable
//
// Operation
// RULE_01 - array of 32K or 16K words, 18 bits; small variant ignores MSB
// RULE_02 - both ports reach any location at once, same one included
// RULE_03 - controls, address, write data captured on each port clock rise
// RULE_04 - flow-through or pipelined output; pipelined adds one port cycle
// RULE_05 - lane selects pass one register stage in both modes
// RULE_06 - chip selects registered once flow-through, twice pipelined
// RULE_07 - deselected port does no access and floats both lanes
// RULE_08 - write lands only in enabled lanes, upper 9-17, lower 0-8
// RULE_09 - read drives only lanes selected low, other lane floats
// RULE_10 - output enable high floats all data lines without clock
// RULE_11 - load strobe low loads external address regardless of selects
// RULE_12 - advance low increments internal address regardless of selects
// RULE_13 - load, advance, clear all high reuse previous address
// RULE_14 - clear low forces address zero, over load and advance
// RULE_15 - master should hold read-not-write high while loading address
// RULE_16 - counter wraps from top of array to zero
`timescale 1ns/1ns
`include "dpram_regs.svh"

module dpram_ports
   import dpram_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
)(
   // system
   input  wire logic                  SYS_CLK,
   input  wire logic                  RST_N,
   // port clocks, index 0 is left, 1 is right
   input  wire logic [`PORT_N-1:0]    PORT_CLK,
   // selects and direction
   input  wire logic [`PORT_N-1:0]    CHIP_SELECT_LOW_ACTIVE_N,
   input  wire logic [`PORT_N-1:0]    CHIP_SELECT_HIGH_ACTIVE,
   input  wire logic [`PORT_N-1:0]    READ_NOT_WRITE,
   input  wire logic [`PORT_N-1:0]    OUTPUT_ENABLE_N,
   input  wire logic [`PORT_N-1:0]    UPPER_LANE_SELECT_N,
   input  wire logic [`PORT_N-1:0]    LOWER_LANE_SELECT_N,
   // address counter and output stage select
   input  wire logic [`PORT_N-1:0]    ADDRESS_LOAD_STROBE_N,
   input  wire logic [`PORT_N-1:0]    ADDRESS_ADVANCE_N,
   input  wire logic [`PORT_N-1:0]    ADDRESS_CLEAR_N,
   input  wire logic [`PORT_N-1:0]    OUTPUT_STAGE_SELECT,
   input  wire logic [`ADDR_MSB:0]    PORT_ADDRESS    [`PORT_N],
   // data lines, split into input, output and enable
   input  wire logic [`DATA_MSB:0]    PORT_DATA_LINES_I  [`PORT_N],
   output      logic [`DATA_MSB:0]    PORT_DATA_LINES_O  [`PORT_N],
   output      logic [`DATA_MSB:0]    PORT_DATA_LINES_OE [`PORT_N]
);

   // ****************************************************************
   // storage
   // ****************************************************************
   // RULE_01 array depth
   logic [`DATA_MSB:0] mem [`DEPTH_LARGE];

   // the small variant drops the top address bit everywhere
   localparam logic [`ADDR_MSB:0] ADDR_MASK =
      SMALL_VARIANT ? `SMALL_MASK : `FULL_MASK;

   // per-port signals, all but rd_q seen by the shared array process
   logic [`PORT_N-1:0]  access_q;
   logic [`ADDR_MSB:0]  addr_q   [`PORT_N];
   logic [`DATA_MSB:0]  wdata_q  [`PORT_N];
   port_ctl_t           ctl_q    [`PORT_N];
   logic [`DATA_MSB:0]  rd_q     [`PORT_N];

   // ****************************************************************
   // array access, one process so both write ports share one driver
   // ****************************************************************
   // RULE_02 concurrent ports
   // equal-address writes in one cycle: the right port lands last
   always_ff @(posedge SYS_CLK) begin
      for (int p = 0; p < `PORT_N; p++) begin
         // RULE_08 lane masked write
         if (access_q[p] && ctl_q[p].sel && !ctl_q[p].read_not_write) begin
            if (!ctl_q[p].upper_n) begin
               mem[addr_q[p]][`UPPER_HI:`UPPER_LO] <=
                  wdata_q[p][`UPPER_HI:`UPPER_LO];
            end
            if (!ctl_q[p].lower_n) begin
               mem[addr_q[p]][`LOWER_HI:`LOWER_LO] <=
                  wdata_q[p][`LOWER_HI:`LOWER_LO];
            end
         end
      end
   end

   // ****************************************************************
   // per-port logic
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < `PORT_N; g++) begin : gen_port
         port_in_t           pin_now;
         port_in_t           in_s1_q;
         port_in_t           in_s2_q;
         logic               clk_s1_q;
         logic               clk_s2_q;
         logic               clk_s3_q;
         logic               rise;
         logic [`ADDR_MSB:0] addr_d;
         logic               sel_d;
         logic               sel2_q;
         logic               rnw2_q;
         logic [`DATA_MSB:0] pipe_q;
         logic               drive_sel;
         logic               drive_rnw;
         logic [`DATA_MSB:0] lane_en;

         assign pin_now = '{
            cs_low_n:       CHIP_SELECT_LOW_ACTIVE_N[g],
            cs_high:        CHIP_SELECT_HIGH_ACTIVE[g],
            read_not_write: READ_NOT_WRITE[g],
            upper_n:        UPPER_LANE_SELECT_N[g],
            lower_n:        LOWER_LANE_SELECT_N[g],
            load_n:         ADDRESS_LOAD_STROBE_N[g],
            advance_n:      ADDRESS_ADVANCE_N[g],
            clear_n:        ADDRESS_CLEAR_N[g],
            pipe_mode:      OUTPUT_STAGE_SELECT[g],
            addr:           PORT_ADDRESS[g],
            wdata:          PORT_DATA_LINES_I[g]
         };

         // ***********************************************************
         // pin synchronisers
         // ***********************************************************
         // clock and pins share the same two-stage delay, so the
         // values seen at the detected rise are those set up before it
         always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
               clk_s1_q <= 1'b0;
               clk_s2_q <= 1'b0;
               clk_s3_q <= 1'b0;
               in_s1_q  <= '0;
               in_s2_q  <= '0;
            end else begin
               clk_s1_q <= PORT_CLK[g];
               clk_s2_q <= clk_s1_q;
               clk_s3_q <= clk_s2_q;
               in_s1_q  <= pin_now;
               in_s2_q  <= in_s1_q;
            end
         end

         assign rise = clk_s2_q & ~clk_s3_q;

         // ***********************************************************
         // address counter
         // ***********************************************************
         always_comb begin
            // RULE_14 clear wins
            if (!in_s2_q.clear_n) begin
               addr_d = `ADDR_ZERO;
            // RULE_11 external load
            end else if (!in_s2_q.load_n) begin
               addr_d = in_s2_q.addr & ADDR_MASK;
            // RULE_12 advance by one
            end else if (!in_s2_q.advance_n) begin
               // RULE_16 wrap at top
               addr_d = (addr_q[g] + `ADDR_ONE) & ADDR_MASK;
            // RULE_13 hold previous
            end else begin
               addr_d = addr_q[g];
            end
         end

         // RULE_15 no write guard; master keeps read-not-write high
         always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
               addr_q[g] <= `ADDR_ZERO;
            end else if (rise) begin
               addr_q[g] <= addr_d;
            end
         end

         // ***********************************************************
         // input registers
         // ***********************************************************
         // RULE_07 deselect decode
         assign sel_d = !in_s2_q.cs_low_n && in_s2_q.cs_high;

         // RULE_03 capture on port rise
         always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
               ctl_q[g]    <= '{sel: 1'b0, read_not_write: 1'b1,
                                upper_n: 1'b1, lower_n: 1'b1,
                                pipe_mode: 1'b0};
               wdata_q[g]  <= `DATA_ZERO;
               access_q[g] <= 1'b0;
            end else begin
               access_q[g] <= rise;
               if (rise) begin
                  // RULE_05 single lane stage
                  ctl_q[g]   <= '{sel: sel_d,
                                  read_not_write: in_s2_q.read_not_write,
                                  upper_n: in_s2_q.upper_n,
                                  lower_n: in_s2_q.lower_n,
                                  pipe_mode: in_s2_q.pipe_mode};
                  wdata_q[g] <= in_s2_q.wdata;
               end
            end
         end

         // ***********************************************************
         // read path
         // ***********************************************************
         // deselected ports skip the read to mimic standby
         always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
               rd_q[g] <= `DATA_ZERO;
            end else if (access_q[g] && ctl_q[g].sel
                         && ctl_q[g].read_not_write) begin
               rd_q[g] <= mem[addr_q[g]];
            end
         end

         // RULE_04 pipelined extra stage
         // RULE_06 second select stage
         always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
               pipe_q <= `DATA_ZERO;
               sel2_q <= 1'b0;
               rnw2_q <= 1'b1;
            end else if (rise) begin
               pipe_q <= rd_q[g];
               sel2_q <= ctl_q[g].sel;
               rnw2_q <= ctl_q[g].read_not_write;
            end
         end

         // ***********************************************************
         // output drive
         // ***********************************************************
         // RULE_06 select depth by mode
         assign drive_sel = ctl_q[g].pipe_mode ? sel2_q : ctl_q[g].sel;
         assign drive_rnw = ctl_q[g].pipe_mode ? rnw2_q
                                               : ctl_q[g].read_not_write;

         // RULE_09 selected lanes only
         assign lane_en = {{`LANE_W{!ctl_q[g].upper_n}},
                           {`LANE_W{!ctl_q[g].lower_n}}};

         assign PORT_DATA_LINES_O[g] =
            ctl_q[g].pipe_mode ? pipe_q : rd_q[g];

         // RULE_10 asynchronous output enable
         // raw pin gates the drivers on purpose: a synchroniser here
         // would add the very clock delay this pin must not have
         assign PORT_DATA_LINES_OE[g] =
            (OUTPUT_ENABLE_N[g] || !drive_sel || !drive_rnw)
               ? `DATA_ZERO : lane_en;
      end
   endgenerate

endmodule : dpram_ports

// ===== rtl/dpram_regs.svh
// Purpose: named constants of the dual-port ram port logic
// Assumes: included by bare name from the package and the design
// Notes:   widths and field positions of the data and address paths
`ifndef DPRAM_REGS_SVH
`define DPRAM_REGS_SVH

// ****************************************************************
// array shape
// ****************************************************************
`define ADDR_W        15
`define ADDR_MSB      14
`define DATA_W        18
`define DATA_MSB      17
`define PORT_N        2
`define DEPTH_LARGE   32768

// ****************************************************************
// byte lanes
// ****************************************************************
`define LOWER_LO      0
`define LOWER_HI      8
`define UPPER_LO      9
`define UPPER_HI      17
`define LANE_W        9

// ****************************************************************
// reset and counter values
// ****************************************************************
`define ADDR_ZERO     15'h0000
`define ADDR_ONE      15'h0001
`define DATA_ZERO     18'h00000
`define SMALL_MASK    15'h3FFF
`define FULL_MASK     15'h7FFF

`endif

// ===== sim/dpram_master.sv
// Purpose: synchronous bus master for one ram port
// Assumes: port clock made from SYS_CLK, high HALF cycles, low HALF plus 3
// Notes:   port clock stands low between operations
`timescale 1ns/1ns
`include "dpram_regs.svh"
module dpram_master
   import dpram_pkg::*;
#(
   parameter int HALF = 5
)(
   // system
   input  wire logic               SYS_CLK,
   // port pins
   output      logic               pclk = 1'b0,
   output      logic               out_en_n = 1'b1,
   output      port_in_t           pins = '0,
   // data lines, released lines show the write data, inverted during reads
   input  wire logic [`DATA_MSB:0] oe,
   input  wire logic [`DATA_MSB:0] dout,
   output wire logic [`DATA_MSB:0] dio
);
   // write history, newest in bit 0
   logic [2:0] wr_hist = 3'h0;
   assign dio = (oe & dout) |
                (~oe & (pins.read_not_write ? ~pins.wdata : pins.wdata));
   // ********************
   // one port cycle, pins held through the whole clock period
   // ********************
   task automatic op(input port_in_t v, input logic en_n);
      @(posedge SYS_CLK);
      v.read_not_write = v.read_not_write | ~v.load_n;
      wr_hist = {wr_hist[1:0], ~v.read_not_write};
      pins     <= v;
      // drivers stay enabled through a write only after two writes,
      // so the port itself must float them; earlier would collide
      out_en_n <= en_n | (wr_hist[0] & ~(wr_hist[1] & wr_hist[2]));
      repeat (2) @(posedge SYS_CLK);
      pclk <= 1'b1;
      repeat (HALF) @(posedge SYS_CLK);
      pclk <= 1'b0;
      repeat (HALF) @(posedge SYS_CLK);
      #1;
   endtask : op
   task automatic set_en(input logic en_n);
      @(posedge SYS_CLK);
      out_en_n <= en_n;
      #1;
   endtask : set_en
endmodule : dpram_master

// ===== sim/dpram_ports_checker.sv
// Purpose: port 0 output checks of the dual-port ram, plus port 1 output enable
// Assumes: port clock periods of at least 10 SYS_CLK
// Notes:   port 0 pins are recorded at each raw port 0 clock rise
`timescale 1ns/1ns
`include "dpram_regs.svh"
module dpram_ports_checker
   import dpram_pkg::*;
(
   // system
   input wire logic               SYS_CLK,
   input wire logic               RST_N,
   // port controls
   input wire logic [`PORT_N-1:0] PORT_CLK,
   input wire logic [`PORT_N-1:0] CHIP_SELECT_LOW_ACTIVE_N,
   input wire logic [`PORT_N-1:0] CHIP_SELECT_HIGH_ACTIVE,
   input wire logic [`PORT_N-1:0] READ_NOT_WRITE,
   input wire logic [`PORT_N-1:0] OUTPUT_ENABLE_N,
   input wire logic [`PORT_N-1:0] UPPER_LANE_SELECT_N,
   input wire logic [`PORT_N-1:0] LOWER_LANE_SELECT_N,
   // data outputs
   input wire logic [`DATA_MSB:0] PORT_DATA_LINES_O  [`PORT_N],
   input wire logic [`DATA_MSB:0] PORT_DATA_LINES_OE [`PORT_N]
);
   wire [`DATA_MSB:0] oe0;
   wire               rise;
   wire               off;
   logic              pclk_q;
   logic [3:0]        since_q;
   logic [1:0]        cs_q;
   logic [1:0]        wr_q;
   logic [1:0]        ln_q;
   assign oe0  = PORT_DATA_LINES_OE[0];
   assign rise = PORT_CLK[0] & ~pclk_q;
   assign off  = CHIP_SELECT_LOW_ACTIVE_N[0] | ~CHIP_SELECT_HIGH_ACTIVE[0];
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // ********************
   // pin history, cheaper than a full port model
   // ********************
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pclk_q  <= 1'b0;
         since_q <= 4'hF;
      end else begin
         pclk_q  <= PORT_CLK[0];
         since_q <= rise ? 4'h0 : since_q + {3'h0, ~&since_q};
      end
   end
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cs_q <= 2'h0;
         wr_q <= 2'h0;
         ln_q <= 2'h0;
      end else if (rise) begin
         cs_q <= {cs_q[0], off};
         wr_q <= {wr_q[0], ~READ_NOT_WRITE[0]};
         ln_q <= {ln_q[0], UPPER_LANE_SELECT_N[0] & LOWER_LANE_SELECT_N[0]};
      end
   end
   sequence s_settled;
      since_q >= 4'h7;
   endsequence
   property p_oe_off;
      OUTPUT_ENABLE_N[0] |-> oe0 == '0;
   endproperty
   property p_oe_off1;
      OUTPUT_ENABLE_N[1] |-> PORT_DATA_LINES_OE[1] == '0;
   endproperty
   property p_desel;
      s_settled ##0 cs_q == 2'h3 |-> oe0 == '0;
   endproperty
   property p_lane_off;
      s_settled ##0 ln_q[0] |-> oe0 == '0;
   endproperty
   property p_wr_float;
      s_settled ##0 wr_q == 2'h3 |-> oe0 == '0;
   endproperty
   property p_lo_lane;
      oe0[`LOWER_HI:`LOWER_LO] == '0 || oe0[`LOWER_HI:`LOWER_LO] == '1;
   endproperty
   property p_up_lane;
      oe0[`UPPER_HI:`UPPER_LO] == '0 || oe0[`UPPER_HI:`UPPER_LO] == '1;
   endproperty
   property p_out_time;
      $changed(PORT_DATA_LINES_O[0]) |-> since_q inside {[1:7]};
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("port 0 drives while disabled");
   a_oe_off1: assert property (p_oe_off1)
      else $error("port 1 drives while disabled");
   a_desel: assert property (p_desel)
      else $error("deselected port drives");
   a_lane_off: assert property (p_lane_off)
      else $error("lanes off but port drives");
   a_wr_float: assert property (p_wr_float)
      else $error("port drives during writes");
   a_lo_lane: assert property (p_lo_lane)
      else $error("lower lane partly driven");
   a_up_lane: assert property (p_up_lane)
      else $error("upper lane partly driven");
   a_out_time: assert property (p_out_time)
      else $error("read data moved outside a port cycle");
endmodule : dpram_ports_checker

// ===== sim/sync_dual_port_ram_port_tb.sv
// Purpose: self-checking bench of the dual-port ram port logic
// Assumes: port 0 clock period 13 SYS_CLK, port 1 period 17
// Notes:   data checks are made on port 0, except one read checked on port 1
`timescale 1ns/1ns
`include "dpram_regs.svh"
module sync_dual_port_ram_port_tb
   import dpram_pkg::*;
;
   localparam logic [`ADDR_MSB:0] A = 15'h1234, B = 15'h0400;
   localparam logic [`ADDR_MSB:0] TOP = 15'h7FFF, JUNK = 15'h5555;
   localparam logic [`DATA_MSB:0] D1 = 18'h15A5A, D2 = 18'h3C3C3;
   localparam logic [`DATA_MSB:0] DT = 18'h3F0F0, DZ = 18'h00F0F;
   localparam logic [`DATA_MSB:0] DB = 18'h1C0DE, ALL = 18'h3FFFF;
   localparam logic [`DATA_MSB:0] LANE = {D1[17:9], D2[8:0]};
   localparam logic [7:0] LD_RD = 8'h63, WR = 8'h47, RD = 8'h67;
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic pipe = 1'b0;
   int   num_errors = 0;
   int   tests_run = 0;
   wire logic [`PORT_N-1:0] PORT_CLK, OUTPUT_ENABLE_N, READ_NOT_WRITE;
   wire logic [`PORT_N-1:0] CHIP_SELECT_LOW_ACTIVE_N, CHIP_SELECT_HIGH_ACTIVE;
   wire logic [`PORT_N-1:0] UPPER_LANE_SELECT_N, LOWER_LANE_SELECT_N;
   wire logic [`PORT_N-1:0] ADDRESS_LOAD_STROBE_N, ADDRESS_ADVANCE_N;
   wire logic [`PORT_N-1:0] ADDRESS_CLEAR_N, OUTPUT_STAGE_SELECT;
   wire logic [`ADDR_MSB:0] PORT_ADDRESS [`PORT_N];
   wire logic [`DATA_MSB:0] PORT_DATA_LINES_I [`PORT_N];
   wire logic [`DATA_MSB:0] PORT_DATA_LINES_O [`PORT_N];
   wire logic [`DATA_MSB:0] PORT_DATA_LINES_OE [`PORT_N];
   wire port_in_t           pins [`PORT_N];
   for (genvar p = 0; p < `PORT_N; p++) begin : g_port
      dpram_master #(.HALF(5 + 2 * p)) master_i (.SYS_CLK,
         .pclk(PORT_CLK[p]), .out_en_n(OUTPUT_ENABLE_N[p]), .pins(pins[p]),
         .oe(PORT_DATA_LINES_OE[p]), .dout(PORT_DATA_LINES_O[p]),
         .dio(PORT_DATA_LINES_I[p]));
      assign {CHIP_SELECT_LOW_ACTIVE_N[p], CHIP_SELECT_HIGH_ACTIVE[p],
              READ_NOT_WRITE[p], UPPER_LANE_SELECT_N[p],
              LOWER_LANE_SELECT_N[p], ADDRESS_LOAD_STROBE_N[p],
              ADDRESS_ADVANCE_N[p], ADDRESS_CLEAR_N[p],
              OUTPUT_STAGE_SELECT[p], PORT_ADDRESS[p]} = pins[p][41:18];
   end
   dpram_ports dpram_ports_i (.SYS_CLK, .RST_N, .PORT_CLK,
      .CHIP_SELECT_LOW_ACTIVE_N, .CHIP_SELECT_HIGH_ACTIVE, .READ_NOT_WRITE,
      .OUTPUT_ENABLE_N, .UPPER_LANE_SELECT_N, .LOWER_LANE_SELECT_N,
      .ADDRESS_LOAD_STROBE_N, .ADDRESS_ADVANCE_N, .ADDRESS_CLEAR_N,
      .OUTPUT_STAGE_SELECT, .PORT_ADDRESS, .PORT_DATA_LINES_I,
      .PORT_DATA_LINES_O, .PORT_DATA_LINES_OE);
   always #5 SYS_CLK = ~SYS_CLK;
   // ********************
   // shared tasks
   // ********************
   task automatic check(input logic [`DATA_MSB:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input int p, input logic [7:0] c,
                      input logic [`ADDR_MSB:0] a, input logic [`DATA_MSB:0] d);
      if (p == 0) g_port[0].master_i.op({c, pipe, a, d}, 1'b0);
      else g_port[1].master_i.op({c, pipe, a, d}, 1'b0);
   endtask : acc
   task automatic rd(input logic [`DATA_MSB:0] d, oe);
      check(PORT_DATA_LINES_O[0] & PORT_DATA_LINES_OE[0], d & oe);
      check(PORT_DATA_LINES_OE[0], oe);
   endtask : rd
   // ********************
   // scenarios
   // ********************
   task automatic test_lanes;
      acc(0, LD_RD, A, '0);
      acc(0, WR, JUNK, 18'h2A5A5);
      acc(0, 8'h4F, JUNK, D1);
      acc(0, 8'h57, JUNK, D2);
      acc(0, 8'h5F, JUNK, '0);
      acc(0, 8'h6F, JUNK, '0);
      rd(LANE, 18'h3FE00);
      acc(0, 8'h7F, JUNK, '0);
      check(PORT_DATA_LINES_OE[0], '0);
      acc(0, RD, JUNK, '0);
      rd(LANE, ALL);
      $display("lanes test done");
   endtask : test_lanes
   task automatic test_counter;
      acc(0, LD_RD, TOP, '0);
      acc(0, WR, JUNK, DT);
      acc(0, 8'h46, TOP, DZ);
      acc(0, 8'hE3, TOP, '0);
      acc(0, 8'h65, JUNK, '0);
      rd(DZ, ALL);
      acc(0, LD_RD, TOP, '0);
      rd(DT, ALL);
      acc(0, 8'h62, TOP, '0);
      rd(DZ, ALL);
      $display("counter test done");
   endtask : test_counter
   task automatic test_pipe;
      pipe = 1'b1;
      acc(0, LD_RD, TOP, '0);
      acc(0, LD_RD, A, '0);
      rd(DT, ALL);
      acc(0, RD, JUNK, '0);
      rd(LANE, ALL);
      acc(0, 8'hE7, JUNK, '0);
      check(PORT_DATA_LINES_OE[0], ALL);
      acc(0, 8'hE7, JUNK, '0);
      check(PORT_DATA_LINES_OE[0], '0);
      pipe = 1'b0;
      $display("pipe test done");
   endtask : test_pipe
   task automatic test_ports;
      fork
         begin
            acc(1, LD_RD, B, '0);
            acc(1, WR, JUNK, DB);
         end
         acc(0, LD_RD, A, '0);
      join
      rd(LANE, ALL);
      acc(0, LD_RD, B, '0);
      rd(DB, ALL);
      acc(1, LD_RD, A, '0);
      check(PORT_DATA_LINES_O[1], LANE);
      check(PORT_DATA_LINES_OE[1], ALL);
      g_port[0].master_i.set_en(1'b1);
      check(PORT_DATA_LINES_OE[0], '0);
      g_port[0].master_i.set_en(1'b0);
      check(PORT_DATA_LINES_OE[0], ALL);
      $display("ports test done");
   endtask : test_ports
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      test_lanes();
      test_counter();
      test_pipe();
      test_ports();
      end_of_test();
   end
   // whole run needs under 1000 cycles, so 20000 means a hang
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      num_errors++;
      end_of_test();
   end
endmodule : sync_dual_port_ram_port_tb
bind dpram_ports dpram_ports_checker checker_i (.SYS_CLK, .RST_N, .PORT_CLK,
   .CHIP_SELECT_LOW_ACTIVE_N, .CHIP_SELECT_HIGH_ACTIVE, .READ_NOT_WRITE,
   .OUTPUT_ENABLE_N, .UPPER_LANE_SELECT_N, .LOWER_LANE_SELECT_N,
   .PORT_DATA_LINES_O, .PORT_DATA_LINES_OE);
